// >>> inc/sbsc_pkg.sv
// Overview of operation
// - Burst order select low steps low address bits linearly, wrapping on fifth clock.
// - Burst order select high XORs start bits with count, interleaved order.
// - Unconnected mode pins default: deselect depth and flow-through high, others low.
// - Sleep request high gives standby; deselect depth low selects dual-cycle deselect.
// - Parity enable low runs four parity lanes; high deactivates them.
// - Write request is global write low, or byte write gate low.
// - Byte write gate alone writes exactly the lanes whose strobes are low.
// - Read cycles drive all byte lanes regardless of lane strobes.
// - Write cycles keep every data lane driver off.
// - Lanes c and d exist only in 32 and 36 bit organisations.
// - Address strobe with a false chip select performs a deselect cycle, except a processor strobe with chip select one high.
// - Processor strobe is ignored while chip select one is high.
// - Selected processor strobe loads address and begins a read burst.
// - Selected controller strobe loads address and begins read or write burst.
// - No loading strobe with advance low steps to the next burst address.
// - No loading strobe with advance high repeats access at current address.
// - Output enable acts asynchronously and only gates drivers already active.
// - Dummy reads advance the burst counter like normal reads.
// - Two lowest address inputs preset the burst counter when a burst begins.
// - Advance, write and lane strobes active low; chip select two, sleep high.
package sbsc_pkg;
    localparam int ADDR_W = 18;
    localparam int LANES = 4;
    localparam int LANE_W = 9;
    localparam int DATA_W = LANES * LANE_W;
    localparam int CNT_W = 2;
    localparam int PAR_BIT = 8;
    localparam logic [CNT_W-1:0] CNT_ZERO = 2'h0;
    localparam logic [CNT_W-1:0] CNT_ONE = 2'h1;
    localparam int BUF_DEPTH = 2;
    // Decoded synchronous cycle kinds
    typedef enum logic [4:0] {
        SBSC_IDLE  = 5'h01,
        SBSC_DESEL = 5'h02,
        SBSC_BEGIN = 5'h04,
        SBSC_NEXT  = 5'h08,
        SBSC_HOLD  = 5'h10
    } sbsc_cyc_t;
endpackage : sbsc_pkg

// >>> logic/sbsc_buf.sv
`timescale 1ns/100ps
`default_nettype none
// Two-entry buffer for read data towards the bus
module sbsc_buf (
    input wire logic mclk,
    input wire logic rstn,
    input wire logic ce,
    input wire logic in_valid,
    output logic in_ready,
    input wire logic [sbsc_pkg::DATA_W-1:0] in_data,
    output logic out_valid,
    input wire logic out_ready,
    output logic [sbsc_pkg::DATA_W-1:0] out_data
);
    typedef struct packed {
        logic [1:0] cnt;
        logic [sbsc_pkg::DATA_W-1:0] d0;
        logic [sbsc_pkg::DATA_W-1:0] d1;
    } sbsc_buf_t;
    sbsc_buf_t st, next_st;
    logic push, pop;

    assign in_ready = (st.cnt != 2'(sbsc_pkg::BUF_DEPTH));
    assign out_valid = (st.cnt != 2'h0);
    assign out_data = st.d0;
    assign push = in_valid && in_ready;
    assign pop = out_valid && out_ready;

    // Shift register style queue
    always_comb begin
        next_st = st;
        if (pop) begin
            next_st.d0 = st.d1;
        end
        if (push) begin
            if (st.cnt == 2'h0 || (st.cnt == 2'h1 && pop)) begin
                next_st.d0 = in_data;
            end else begin
                next_st.d1 = in_data;
            end
        end
        next_st.cnt = st.cnt + 2'(push) - 2'(pop);
    end

    always_ff @(posedge mclk) begin
        if (!rstn) begin
            st <= '0;
        end else if (ce) begin
            st <= next_st;
        end
    end
endmodule : sbsc_buf
`default_nettype wire

// >>> logic/sbsc_ctrl.sv
`timescale 1ns/100ps
`default_nettype none
// Synchronous burst memory control core
module sbsc_ctrl (
    input wire logic mclk,
    input wire logic rstn,
    input wire logic ce,
    input wire logic chip_sel1_n,
    input wire logic chip_sel2,
    input wire logic chip_sel3_n,
    input wire logic proc_addr_strobe_n,
    input wire logic ctrl_addr_strobe_n,
    input wire logic burst_advance_n,
    input wire logic global_write_n,
    input wire logic byte_write_gate_n,
    input wire logic lane_a_write_n,
    input wire logic lane_b_write_n,
    input wire logic lane_c_write_n,
    input wire logic lane_d_write_n,
    input wire logic out_enable_n,
    input wire logic burst_order_sel,
    input wire logic flow_through_sel,
    input wire logic deselect_depth_sel,
    input wire logic sleep_req,
    input wire logic parity_byte_en,
    input wire logic wide_org,
    input wire logic [sbsc_pkg::ADDR_W-1:0] addr,
    input wire logic [sbsc_pkg::DATA_W-1:0] dq_in,
    output logic [sbsc_pkg::DATA_W-1:0] dq_out,
    output logic [sbsc_pkg::DATA_W-1:0] dq_oe,
    output logic standby,
    output logic [sbsc_pkg::ADDR_W-1:0] cur_addr,
    output logic rd_valid,
    input wire logic rd_ready,
    output logic [sbsc_pkg::DATA_W-1:0] rd_data
);
    typedef struct packed {
        sbsc_pkg::sbsc_cyc_t cyc;
        logic [sbsc_pkg::ADDR_W-1:0] base;
        logic [sbsc_pkg::CNT_W-1:0] start;
        logic [sbsc_pkg::CNT_W-1:0] cnt;
        logic rd_q;
        logic rd_p;
        logic drv_q;
        logic drv_p;
        logic [sbsc_pkg::DATA_W-1:0] q_hold;
    } sbsc_ctrl_t;
    sbsc_ctrl_t st, next_st;

    logic sel, wr_req, load, desel, step, access;
    logic [sbsc_pkg::LANES-1:0] lane_n, lane_we, lane_live;
    logic [sbsc_pkg::CNT_W-1:0] lo_bits, next_cnt;
    logic [sbsc_pkg::ADDR_W-1:0] acc_addr;
    logic [sbsc_pkg::DATA_W-1:0] mem_q, lane_mask;
    logic run, buf_in_ready, drive;

    // Sleep stops all synchronous activity
    assign standby = sleep_req;
    assign run = ce && !sleep_req;

    // Chip select and write decode
    assign sel = !chip_sel1_n && chip_sel2 && !chip_sel3_n;
    assign wr_req = !global_write_n || !byte_write_gate_n;
    assign lane_n = {lane_d_write_n, lane_c_write_n,
                     lane_b_write_n, lane_a_write_n};
    // Lanes c and d only exist in the wide organisation
    assign lane_live = {wide_org, wide_org, 2'h3};
    assign lane_we = (!global_write_n ? {sbsc_pkg::LANES{1'b1}} :
                      ~lane_n) & lane_live;

    // Cycle decode, processor strobe ignored when chip select one high
    assign load = sel && (!proc_addr_strobe_n ||
                  !ctrl_addr_strobe_n);
    assign desel = !sel && (!ctrl_addr_strobe_n ||
                   (!chip_sel1_n && !proc_addr_strobe_n));
    assign step = !load && !desel && !burst_advance_n;
    assign access = load || (!desel);

    // Processor strobe begin is always a read
    logic is_wr;
    assign is_wr = load ? (proc_addr_strobe_n && wr_req) : wr_req;

    // Burst counter: cleared at begin, low address kept as start, step count
    assign next_cnt = load ? sbsc_pkg::CNT_ZERO :
                      step ? st.cnt + sbsc_pkg::CNT_ONE : st.cnt;
    always_comb begin
        logic [sbsc_pkg::CNT_W-1:0] s;
        s = load ? addr[sbsc_pkg::CNT_W-1:0] : st.start;
        if (burst_order_sel) begin
            lo_bits = s ^ next_cnt;
        end else begin
            lo_bits = s + next_cnt;
        end
    end
    assign acc_addr = {(load ? addr[sbsc_pkg::ADDR_W-1:sbsc_pkg::CNT_W] :
                        st.base[sbsc_pkg::ADDR_W-1:sbsc_pkg::CNT_W]),
                       lo_bits};
    assign cur_addr = acc_addr;

    sbsc_mem i_sbsc_mem (
        .mclk(mclk),
        .ce(run && access),
        .wr(access && is_wr),
        .lane_we(lane_we),
        .addr(acc_addr),
        .wdata(dq_in),
        .rdata(mem_q)
    );

    // State update
    always_comb begin
        next_st = st;
        next_st.cnt = next_cnt;
        if (load) begin
            next_st.base = addr;
            next_st.start = addr[sbsc_pkg::CNT_W-1:0];
        end
        unique case (1'b1)
            load: next_st.cyc = sbsc_pkg::SBSC_BEGIN;
            desel: next_st.cyc = sbsc_pkg::SBSC_DESEL;
            step: next_st.cyc = sbsc_pkg::SBSC_NEXT;
            default: next_st.cyc = sbsc_pkg::SBSC_HOLD;
        endcase
        // Read in flight: drivers on only for reads
        next_st.rd_q = access && !is_wr;
        next_st.rd_p = st.rd_q;
        next_st.drv_q = access && !is_wr;
        // Single deselect cuts drivers at capture; dual keeps one more cycle
        // A write cycle never lets the pipelined drivers on
        next_st.drv_p = st.drv_q && !(access && is_wr)
                        && (!deselect_depth_sel || !desel);
        if (st.rd_q) begin
            next_st.q_hold = mem_q;
        end
    end

    always_ff @(posedge mclk) begin
        if (!rstn) begin
            st <= '{cyc: sbsc_pkg::SBSC_IDLE, default: '0};
        end else if (run) begin
            st <= next_st;
        end
    end

    // Flow-through shows array output now; pipelined one edge later
    assign drive = flow_through_sel ? st.drv_p : st.drv_q;
    assign rd_data = flow_through_sel ? st.q_hold : mem_q;

    // Parity bits masked off when parity lanes disabled
    generate
        for (genvar i = 0; i < sbsc_pkg::LANES; i++) begin : g_oe
            always_comb begin
                lane_mask[i*sbsc_pkg::LANE_W +: sbsc_pkg::LANE_W] =
                    {sbsc_pkg::LANE_W{drive && lane_live[i] && !out_enable_n}};
                if (parity_byte_en) begin
                    lane_mask[i*sbsc_pkg::LANE_W + sbsc_pkg::PAR_BIT] = 1'b0;
                end
            end
        end
    endgenerate
    assign dq_oe = lane_mask;

    // Read words also go out through a two-entry buffer that drops words arriving while it is full
    sbsc_buf i_sbsc_buf (
        .mclk(mclk),
        .rstn(rstn),
        .ce(run),
        .in_valid(flow_through_sel ? st.rd_p : st.rd_q),
        .in_ready(buf_in_ready),
        .in_data(rd_data),
        .out_valid(rd_valid),
        .out_ready(rd_ready),
        .out_data(dq_out)
    );
endmodule : sbsc_ctrl
`default_nettype wire

// >>> logic/sbsc_mem.sv
`timescale 1ns/100ps
`default_nettype none
// Array with registered read data and per-lane writes
module sbsc_mem (
    input wire logic mclk,
    input wire logic ce,
    input wire logic wr,
    input wire logic [sbsc_pkg::LANES-1:0] lane_we,
    input wire logic [sbsc_pkg::ADDR_W-1:0] addr,
    input wire logic [sbsc_pkg::DATA_W-1:0] wdata,
    output logic [sbsc_pkg::DATA_W-1:0] rdata
);
    logic [sbsc_pkg::DATA_W-1:0] mem [0:(1<<sbsc_pkg::ADDR_W)-1];

    // Lane writes and registered read, one process owns the array
    always_ff @(posedge mclk) begin
        if (ce) begin
            for (int i = 0; i < sbsc_pkg::LANES; i++) begin
                if (wr && lane_we[i]) begin
                    mem[addr][i*sbsc_pkg::LANE_W +: sbsc_pkg::LANE_W] <=
                        wdata[i*sbsc_pkg::LANE_W +: sbsc_pkg::LANE_W];
                end
            end
            rdata <= mem[addr];
        end
    end
endmodule : sbsc_mem
`default_nettype wire

// >>> sim/sbsc_ctrl_properties.sv
`timescale 1ns/100ps
`default_nettype none
// Port-level checks of the burst memory control core
module sbsc_ctrl_chk (
    input wire logic mclk,
    input wire logic rstn,
    input wire logic ce,
    input wire logic chip_sel1_n,
    input wire logic chip_sel2,
    input wire logic chip_sel3_n,
    input wire logic proc_addr_strobe_n,
    input wire logic ctrl_addr_strobe_n,
    input wire logic burst_advance_n,
    input wire logic global_write_n,
    input wire logic byte_write_gate_n,
    input wire logic out_enable_n,
    input wire logic burst_order_sel,
    input wire logic flow_through_sel,
    input wire logic deselect_depth_sel,
    input wire logic sleep_req,
    input wire logic parity_byte_en,
    input wire logic [sbsc_pkg::ADDR_W-1:0] addr,
    input wire logic [sbsc_pkg::DATA_W-1:0] dq_oe,
    input wire logic standby,
    input wire logic [sbsc_pkg::ADDR_W-1:0] cur_addr
);
    logic run, sel, beg, ld, acc, dsl, wr, wcy, rcy, pip;
    // Decode of the command sampled at each edge
    assign run = ce && !sleep_req;
    assign sel = !chip_sel1_n && chip_sel2 && !chip_sel3_n;
    assign beg = run && sel && !(proc_addr_strobe_n && ctrl_addr_strobe_n);
    assign ld = !ctrl_addr_strobe_n || (!proc_addr_strobe_n && !chip_sel1_n);
    assign acc = run && (beg || !ld);
    assign dsl = run && !sel && ld;
    assign wr = !global_write_n || !byte_write_gate_n;
    assign wcy = acc && wr && !(beg && !proc_addr_strobe_n);
    assign rcy = acc && !wcy;
    assign pip = flow_through_sel && !parity_byte_en;
    default clocking @(posedge mclk); endclocking
    default disable iff (!rstn);
    a_oe_gate: assert property (out_enable_n |-> dq_oe == '0)
        else $error("drivers on with output enable high");
    a_begin_addr: assert property (beg |-> cur_addr == addr)
        else $error("begin cycle not at external address");
    a_hold_addr: assert property ($past(acc) && $past(rstn) && acc && !ld
        && burst_advance_n |-> cur_addr == $past(cur_addr))
        else $error("suspended burst moved its address");
    a_next_lin: assert property ($past(acc) && $past(rstn) && acc && !ld
        && !burst_advance_n && !burst_order_sel |-> cur_addr ==
        {$past(cur_addr[17:2]), $past(cur_addr[1:0]) + 2'h1})
        else $error("linear burst step wrong");
    a_write_off: assert property (wcy && flow_through_sel |=> dq_oe == '0)
        else $error("drivers on after write cycle");
    a_read_drive: assert property (rcy && pip ##1 run && !wcy && !dsl
        ##1 !out_enable_n |-> dq_oe == '1)
        else $error("read cycle not driving all lanes");
    a_desel_scd: assert property (dsl && deselect_depth_sel && flow_through_sel
        |=> dq_oe == '0)
        else $error("single deselect left drivers on");
    a_dcd_hold: assert property (rcy && pip && !deselect_depth_sel ##1 dsl
        ##1 !out_enable_n |-> dq_oe == '1)
        else $error("dual deselect cut drivers early");
    a_standby_pin: assert property (standby == sleep_req)
        else $error("standby does not follow sleep request");
    c_write: cover property (beg && wcy);
    c_next: cover property (acc && !ld && !burst_advance_n);
    c_desel: cover property (dsl);
endmodule : sbsc_ctrl_chk
bind sbsc_ctrl sbsc_ctrl_chk i_sbsc_ctrl_chk (.*);
`default_nettype wire

// >>> sim/sbsc_host_model.sv
`timescale 1ns/100ps
`default_nettype none
// Reader at the far side of the read buffer, able to stall
module sbsc_host_model (
    input wire logic mclk,
    input wire logic stall,
    input wire logic rd_valid,
    output logic rd_ready,
    input wire logic [sbsc_pkg::DATA_W-1:0] rd_data,
    output logic [sbsc_pkg::DATA_W-1:0] last_word,
    output var int pops
);
    assign rd_ready = !stall;
    initial pops = 0;
    // Take a word at each edge where valid meets ready
    always @(posedge mclk) begin
        if (rd_valid && rd_ready) begin
            last_word <= rd_data;
            pops <= pops + 1;
        end
    end
endmodule : sbsc_host_model
`default_nettype wire

// >>> sim/test_sbsc_ctrl.sv
`timescale 1ns/100ps
`default_nettype none
module test_sbsc_ctrl;
    // Command codes {sel1_n, sel2, proc_n, ctrl_n, adv_n, gw_n, bw_n}
    localparam logic [6:0] WR_GW = 7'h35, WR_BW = 7'h36, RD_C = 7'h37;
    localparam logic [6:0] RD_P = 7'h2d, NXT = 7'h3b, HLD = 7'h6f;
    localparam logic [6:0] DSL = 7'h17;
    localparam logic [17:0] BASE = 18'h00101;
    logic mclk, rstn, ce, chip_sel1_n, chip_sel2, chip_sel3_n, stall;
    logic proc_addr_strobe_n, ctrl_addr_strobe_n, burst_advance_n;
    logic global_write_n, byte_write_gate_n, out_enable_n, wide_org;
    logic lane_a_write_n, lane_b_write_n, lane_c_write_n, lane_d_write_n;
    logic burst_order_sel, flow_through_sel, deselect_depth_sel, sleep_req;
    logic parity_byte_en, standby, rd_valid, rd_ready;
    logic [1:0] lo;
    logic [sbsc_pkg::ADDR_W-1:0] addr, cur_addr;
    logic [sbsc_pkg::DATA_W-1:0] dq_in, dq_out, dq_oe, rd_data, word, last_word;
    int fail_count, total_checks, pops, n, o, i;
    sbsc_ctrl i_sbsc_ctrl (
        .mclk(mclk), .rstn(rstn), .ce(ce),
        .chip_sel1_n(chip_sel1_n), .chip_sel2(chip_sel2),
        .chip_sel3_n(chip_sel3_n),
        .proc_addr_strobe_n(proc_addr_strobe_n),
        .ctrl_addr_strobe_n(ctrl_addr_strobe_n),
        .burst_advance_n(burst_advance_n),
        .global_write_n(global_write_n),
        .byte_write_gate_n(byte_write_gate_n),
        .lane_a_write_n(lane_a_write_n), .lane_b_write_n(lane_b_write_n),
        .lane_c_write_n(lane_c_write_n), .lane_d_write_n(lane_d_write_n),
        .out_enable_n(out_enable_n), .burst_order_sel(burst_order_sel),
        .flow_through_sel(flow_through_sel),
        .deselect_depth_sel(deselect_depth_sel), .sleep_req(sleep_req),
        .parity_byte_en(parity_byte_en), .wide_org(wide_org),
        .addr(addr), .dq_in(dq_in), .dq_out(dq_out), .dq_oe(dq_oe),
        .standby(standby), .cur_addr(cur_addr), .rd_valid(rd_valid),
        .rd_ready(rd_ready), .rd_data(rd_data)
    );
    // The reader takes words from the head of the read buffer
    sbsc_host_model i_sbsc_host_model (
        .mclk(mclk), .stall(stall), .rd_valid(rd_valid),
        .rd_ready(rd_ready), .rd_data(dq_out), .last_word(last_word),
        .pops(pops)
    );
    initial begin
        mclk = 1'b0;
        forever #10 mclk = ~mclk;
    end
    task automatic chk(input logic [35:0] got, input logic [35:0] exp);
        total_checks++;
        if (got !== exp) begin
            fail_count++;
            $display("[ERR] %0t got %h expected %h", $time, got, exp);
        end
    endtask : chk
    // One bus cycle driven at the falling edge
    task automatic op(input logic [6:0] c, input logic [3:0] ln,
            input logic [35:0] d);
        @(negedge mclk);
        {chip_sel1_n, chip_sel2, proc_addr_strobe_n, ctrl_addr_strobe_n,
            burst_advance_n, global_write_n, byte_write_gate_n} <= c;
        {lane_d_write_n, lane_c_write_n, lane_b_write_n, lane_a_write_n} <= ln;
        dq_in <= d;
        #2;
    endtask : op
    task automatic summarize;
        $display("checks %0d mismatches %0d", total_checks, fail_count);
        if (fail_count == 0 && total_checks > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask : summarize
    initial begin
        #50000;
        fail_count++;
        summarize();
    end
    // Main sequence
    initial begin
        {ce, chip_sel3_n, wide_org, flow_through_sel, parity_byte_en} = 5'h16;
        {chip_sel1_n, chip_sel2, proc_addr_strobe_n, ctrl_addr_strobe_n,
            burst_advance_n, global_write_n, byte_write_gate_n} = DSL;
        {lane_d_write_n, lane_c_write_n, lane_b_write_n, lane_a_write_n} = 4'hf;
        {rstn, out_enable_n, stall, burst_order_sel, sleep_req} = 5'h0;
        deselect_depth_sel = 1'b1;
        addr = BASE;
        dq_in = '0;
        repeat (12) @(negedge mclk);
        rstn <= 1'b1;
        op(WR_GW, 4'hf, '1);
        op(WR_BW, 4'ha, '0);
        op(WR_BW, 4'hf, '0);
        op(RD_P, 4'h0, '0);
        op(HLD, 4'h0, '0);
        @(negedge mclk);
        word = {9'h1ff, 9'h000, 9'h1ff, 9'h000};
        chk(dq_oe, '1);
        chk(rd_data, word);
        out_enable_n = 1'b1;
        #1 chk(dq_oe, '0);
        out_enable_n = 1'b0;
        repeat (3) @(negedge mclk);
        stall = 1'b1;
        n = pops;
        op(RD_C, 4'hf, '0);
        op(RD_C, 4'hf, '0);
        op(DSL, 4'hf, '0);
        repeat (3) @(negedge mclk);
        stall = 1'b0;
        repeat (4) @(negedge mclk);
        chk(36'(pops - n), 36'h2);
        chk(last_word, word);
        for (o = 0; o < 2; o++) begin
            burst_order_sel = o[0];
            out_enable_n = o[0]; // Dummy reads in the second pass
            for (i = 0; i < 6; i++) begin
                op(i == 0 ? RD_C : (i == 5 ? HLD : NXT), 4'hf, '0);
                lo = (i == 5) ? 2'h0 : i[1:0];
                lo = o[0] ? (2'h1 ^ lo) : (2'h1 + lo);
                chk(cur_addr, {BASE[17:2], lo});
            end
        end
        op(WR_BW, 4'hf, '0);
        @(negedge mclk);
        out_enable_n = 1'b0;
        #1 chk(dq_oe, '0);
        for (o = 0; o < 2; o++) begin
            deselect_depth_sel = o[0];
            op(RD_C, 4'hf, '0);
            op(DSL, 4'hf, '0);
            op(DSL, 4'hf, '0);
            chk(dq_oe, {36{o[0] == 1'b0}});
        end
        sleep_req = 1'b1;
        #1 chk(standby, 36'h1);
        sleep_req = 1'b0;
        summarize();
    end
endmodule : test_sbsc_ctrl
`default_nettype wire
